// ===== inc/accel_regs.vh
// Register indices, field positions, reset values and timing constants of the register bank
`ifndef ACCEL_SYNC_REGS_VH
`define ACCEL_SYNC_REGS_VH

// Register indices (byte address is four times the index)
`define IDX_VENDOR      8'h00
`define IDX_FAMILY      8'h01
`define IDX_PART        8'h02
`define IDX_REVISION    8'h03
`define IDX_EVENT_FLAGS 8'h04
`define IDX_QUEUE_FILL  8'h05
`define IDX_TEMP_HIGH   8'h06
`define IDX_TEMP_LOW    8'h07
`define IDX_X_UPPER     8'h08
`define IDX_X_MIDDLE    8'h09
`define IDX_X_LOWER     8'h0A
`define IDX_Y_UPPER     8'h0B
`define IDX_Y_MIDDLE    8'h0C
`define IDX_Y_LOWER     8'h0D
`define IDX_Z_UPPER     8'h0E
`define IDX_Z_MIDDLE    8'h0F
`define IDX_FILTER      8'h28
`define IDX_IRQ_MAP     8'h2A
`define IDX_ALIGN       8'h2B
`define IDX_RANGE       8'h2C
`define IDX_POWER       8'h2D
`define IDX_SELF_TEST   8'h2E
`define IDX_SOFT_RESET  8'h2F
`define IDX_IRQ_STATUS  8'h30
`define IDX_IRQ_MASK    8'h31

// Reset values
`define RST_FILTER      8'h00
`define RST_IRQ_MAP     8'h00
`define RST_ALIGN       8'h00
`define RST_RANGE       8'h81
`define RST_POWER       8'h01
`define RST_SELF_TEST   8'h00
`define RST_IRQ         8'h00
`define SOFT_RESET_CODE 8'h5A

// Fields
`define F_OUTPUT_RATE   3:0
`define F_HIGHPASS      6:4
`define F_MAP_TWO       7:4
`define F_ALIGN_MODE    1:0
`define B_CLOCK_SOURCE  2
`define B_IRQ_POLARITY  6
`define B_STANDBY       0
`define B_READY_OFF     2
`define F_SELF_TEST     1:0

// Bits a measurement-mode write may still change
`define LIVE_MASK_FILTER    8'h70
`define LIVE_MASK_SELF_TEST 8'h03

// Alignment modes
`define ALIGN_NONE      2'b00
`define ALIGN_PLAIN     2'b01
`define ALIGN_INTERP    2'b10

// Interrupt status bits
`define IRQ_SAMPLE      0
`define IRQ_STROBE      1
`define IRQ_REFUSED     2

// Timing
`define CLK_HZ          10000000
`define BASE_RATE_SPS   4000
`define INTERP_SHIFT    6

`endif

// ===== logic/pin_route.v
// Registered multiplexer for the second interrupt pin and the sample-ready pin
`timescale 1ns/1ns
`default_nettype none
`include "accel_regs.vh"

module pin_route (
  // Clock and reset
  input  wire       clk,
  input  wire       reset,
  // Selection
  input  wire       clock_source_sel,
  input  wire [1:0] align_mode_sel,
  input  wire [3:0] map_two,
  // Sources
  input  wire       irq_two_level,
  input  wire       ready_level,
  // Pins
  output reg        irq_two_out,
  output reg        irq_two_oe,
  output reg        ready_out,
  output reg        ready_oe
);

  wire map_empty;
  wire aligned;

  assign map_empty = (map_two == 4'h0);
  assign aligned   = (align_mode_sel != `ALIGN_NONE);

  always @(posedge clk) begin
    if (reset) begin
      irq_two_out <= 1'b0;
      irq_two_oe  <= 1'b1;
      ready_out   <= 1'b0;
      ready_oe    <= 1'b1;
    end else begin
      // External clock arrives here, so the pin is never driven
      irq_two_oe  <= ~clock_source_sel;                                    // see R8
      if (clock_source_sel)
        irq_two_out <= 1'b0;                                               // see R8
      else if (aligned)
        irq_two_out <= map_empty ? ready_level : irq_two_level;            // see R12
      else
        irq_two_out <= map_empty ? 1'b0 : irq_two_level;                   // see R7
      // Any alignment mode turns the ready pin into the strobe input
      ready_oe  <= ~aligned;                                               // see R9
      ready_out <= aligned ? 1'b0 : ready_level;                           // see R7
    end
  end

endmodule // pin_route

`default_nettype wire

// ===== logic/accel_sync_pinmux_regmap.v
// Register bank, alignment control and pin multiplexing of a 3-axis accelerometer
//
// Functional notes
// R1: Alignment 10 with external clock: run on outside clock, samples paced by strobes, interpolated.
// R2: Host keeps strobe rate above or at output rate but below 4000 per second.
// R3: Interpolation never changes the passband; filter keeps its programmed rate code.
// R4: Strobe and outside clock obey the same limits as the plain external mode.
// R5: With the outside clock selected, host drives 1.024 MHz on pin two.
// R6: Host holds each strobe high for at least four outside clock cycles.
// R7: Internal clock, no alignment: pin two low if map empty, else interrupt; ready pin ready.
// R8: Outside clock selected: pin two is an input, interrupt two never driven.
// R9: Alignment 10: strobe taken on ready pin, interpolation on, ready active high.
// R10: Alignment 01 with outside clock: strobe on ready pin, no interpolation.
// R11: Alignment 01 on internal clock: every strobe resets the digital filters.
// R12: Aligned, internal clock, empty map: ready goes to pin two; otherwise no ready.
// R13: Software writes all configuration while in standby, then enters measurement.
// R14: In measurement only highpass, map, self-test bits and soft reset accept writes; this bank also takes power, interrupt mask and status writes.
// R15: Event flags: store busy 4, activity 3, overrun 2, watermark 1, sample ready 0.
// R16: The ready indication is active high regardless of interrupt polarity.
// R17: Interpolation resolves the strobe to one sixty-fourth of the output period.
// R18: Reserved bits of read-only registers read zero; writes to them are ignored.
`timescale 1ns/1ns
`default_nettype none
`include "accel_regs.vh"

module accel_sync_pinmux_regmap #(
  parameter [7:0] VENDOR_ID    = 8'h5A,   // Arbitrary value
  parameter [7:0] FAMILY_ID    = 8'h3C,   // Arbitrary value
  parameter [7:0] PART_ID      = 8'h77,   // Arbitrary value
  parameter [7:0] REVISION_ID  = 8'h02,   // Arbitrary value
  parameter       READY_HOLD   = 1250,
  parameter       PERIOD_WIDTH = 24
) (
  // Clock and reset
  input  wire        CLK,
  input  wire        RESET,
  // APB slave
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [7:0]  PADDR,
  input  wire [31:0] PWDATA,
  output reg  [31:0] PRDATA,
  output reg         PREADY,
  output reg         PSLVERR,
  // Interrupt
  output reg         IRQ,
  // Interrupt-two pin (outside clock when selected)
  input  wire        IRQ_PIN_TWO_IN,
  output wire        IRQ_PIN_TWO_OUT,
  output wire        IRQ_PIN_TWO_OE,
  // Sample-ready pin (strobe input when aligned)
  input  wire        SAMPLE_READY_PIN_IN,
  output wire        SAMPLE_READY_PIN_OUT,
  output wire        SAMPLE_READY_PIN_OE,
  // Measurement core results
  input  wire        CORE_SAMPLE_VALID,
  input  wire [19:0] CORE_X,
  input  wire [19:0] CORE_Y,
  input  wire [19:0] CORE_Z,
  input  wire [11:0] CORE_TEMP,
  input  wire [6:0]  CORE_QUEUE_FILL,
  input  wire        CORE_STORE_BUSY,
  input  wire        CORE_ACTIVITY,
  input  wire        CORE_OVERRUN,
  input  wire        CORE_WATERMARK,
  input  wire [3:0]  CORE_IRQ_EVENTS,
  // Measurement core control
  output reg         MEASURE_EN,
  output reg         USE_EXT_CLOCK,
  output reg         INTERP_EN,
  output reg  [3:0]  OUTPUT_RATE,
  output reg  [2:0]  HIGHPASS_CORNER,
  output reg  [1:0]  SELF_TEST,
  output reg         SYNC_STROBE,
  output reg  [5:0]  SYNC_PHASE,
  output reg         FILTER_RESET
);

  localparam [PERIOD_WIDTH-1:0] BASE_CYCLES = `CLK_HZ / `BASE_RATE_SPS;

  // Output period divided into interpolation steps
  function [PERIOD_WIDTH-1:0] step_cycles;
    input [3:0] rate;
    reg   [PERIOD_WIDTH-1:0] period;
    begin
      period      = BASE_CYCLES << rate;
      step_cycles = period >> `INTERP_SHIFT;                               // see R17
    end
  endfunction

  // Byte merge with a write mask
  function [7:0] merge;
    input [7:0] old_val;
    input [7:0] new_val;
    input [7:0] mask;
    begin
      merge = (old_val & ~mask) | (new_val & mask);
    end
  endfunction

  // Configuration and status storage
  reg  [7:0]  filter_reg;
  reg  [7:0]  irq_map_reg;
  reg  [7:0]  align_reg;
  reg  [7:0]  range_reg;
  reg  [7:0]  power_control_reg;
  reg  [7:0]  self_test_reg;
  reg  [7:0]  irq_status_reg;
  reg  [7:0]  irq_mask_reg;
  reg  [19:0] x_reg;
  reg  [19:0] y_reg;
  reg  [19:0] z_reg;
  reg  [11:0] temp_reg;
  reg         ready_reg;
  reg  [15:0] ready_count_reg;
  reg         strobe_prev_reg;
  reg  [PERIOD_WIDTH-1:0] step_count_reg;
  reg  [5:0]  phase_reg;
  reg         irq_two_reg;
  reg  [7:0]  rdata_next;
  reg         err_next;
  reg  [7:0]  irq_status_next;

  wire [7:0]  index;
  wire        setup;
  wire        done;
  wire        wr;
  wire        rd;
  wire        standby;
  wire [1:0]  align_mode_sel;
  wire        clock_source_sel;
  wire        strobe_rise;
  wire        data_read;
  wire        soft_reset;
  wire        refused;
  wire        sample_ready;

  assign index            = {2'b00, PADDR[7:2]};
  assign setup            = PSEL & PENABLE & ~PREADY;
  assign done             = PSEL & PENABLE & PREADY;
  assign wr               = done & PWRITE & ~PSLVERR;
  assign rd               = done & ~PWRITE;
  assign standby          = power_control_reg[`B_STANDBY];
  assign align_mode_sel   = align_reg[`F_ALIGN_MODE];
  assign clock_source_sel = align_reg[`B_CLOCK_SOURCE];
  // Inputs are synchronous, so the strobe edge is taken straight from the pin
  assign strobe_rise      = (align_mode_sel != `ALIGN_NONE) & SAMPLE_READY_PIN_IN
                            & ~strobe_prev_reg;                            // see R9
  assign data_read        = rd & (index >= `IDX_X_UPPER) & (index <= `IDX_Z_MIDDLE);
  assign soft_reset       = wr & (index == `IDX_SOFT_RESET)
                            & (PWDATA[7:0] == `SOFT_RESET_CODE);
  // While measuring, an alignment or range write is dropped and flagged; a filter write is flagged if it changes locked bits
  assign refused          = wr & ~standby & ((index == `IDX_ALIGN) | (index == `IDX_RANGE)
                            | ((index == `IDX_FILTER) &
                               ((PWDATA[7:0] & ~`LIVE_MASK_FILTER) !=
                                (filter_reg & ~`LIVE_MASK_FILTER))));  // see R13
  assign sample_ready     = ready_reg & ~power_control_reg[`B_READY_OFF];

  // Register read mux and address check
  always @* begin
    rdata_next = 8'h00;
    err_next   = (PADDR[1:0] != 2'b00);
    case (index)
      `IDX_VENDOR:      rdata_next = VENDOR_ID;
      `IDX_FAMILY:      rdata_next = FAMILY_ID;
      `IDX_PART:        rdata_next = PART_ID;
      `IDX_REVISION:    rdata_next = REVISION_ID;
      `IDX_EVENT_FLAGS: rdata_next = {3'b000, CORE_STORE_BUSY, CORE_ACTIVITY,
                                      CORE_OVERRUN, CORE_WATERMARK, ready_reg}; // see R15
      `IDX_QUEUE_FILL:  rdata_next = {1'b0, CORE_QUEUE_FILL};                   // see R18
      `IDX_TEMP_HIGH:   rdata_next = {4'h0, temp_reg[11:8]};                    // see R18
      `IDX_TEMP_LOW:    rdata_next = temp_reg[7:0];
      `IDX_X_UPPER:     rdata_next = x_reg[19:12];
      `IDX_X_MIDDLE:    rdata_next = x_reg[11:4];
      `IDX_X_LOWER:     rdata_next = {x_reg[3:0], 4'h0};                        // see R18
      `IDX_Y_UPPER:     rdata_next = y_reg[19:12];
      `IDX_Y_MIDDLE:    rdata_next = y_reg[11:4];
      `IDX_Y_LOWER:     rdata_next = {y_reg[3:0], 4'h0};                        // see R18
      `IDX_Z_UPPER:     rdata_next = z_reg[19:12];
      `IDX_Z_MIDDLE:    rdata_next = z_reg[11:4];
      `IDX_FILTER:      rdata_next = filter_reg;
      `IDX_IRQ_MAP:     rdata_next = irq_map_reg;
      `IDX_ALIGN:       rdata_next = align_reg;
      `IDX_RANGE:       rdata_next = range_reg;
      `IDX_POWER:       rdata_next = power_control_reg;
      `IDX_SELF_TEST:   rdata_next = self_test_reg;
      `IDX_SOFT_RESET:  rdata_next = 8'h00;
      `IDX_IRQ_STATUS:  rdata_next = irq_status_reg;
      `IDX_IRQ_MASK:    rdata_next = irq_mask_reg;
      default:          err_next   = 1'b1;
    endcase
  end

  // Bus handshake: one wait state, answer registered
  always @(posedge CLK) begin
    if (RESET) begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else if (setup) begin
      PREADY  <= 1'b1;
      PRDATA  <= (PWRITE | err_next) ? 32'h0000_0000 : {24'h00_0000, rdata_next};
      PSLVERR <= err_next;
    end else begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end
  end

  // Configuration registers
  always @(posedge CLK) begin
    if (RESET | soft_reset) begin
      filter_reg        <= `RST_FILTER;
      irq_map_reg       <= `RST_IRQ_MAP;
      align_reg         <= `RST_ALIGN;
      range_reg         <= `RST_RANGE;
      power_control_reg <= `RST_POWER;
      self_test_reg     <= `RST_SELF_TEST;
      irq_mask_reg      <= `RST_IRQ;
    end else if (wr) begin
      case (index)
        `IDX_FILTER:
          if (standby)
            filter_reg <= PWDATA[7:0];
          else
            filter_reg <= merge(filter_reg, PWDATA[7:0], `LIVE_MASK_FILTER);      // see R14
        `IDX_IRQ_MAP:   irq_map_reg <= PWDATA[7:0];                               // see R14
        `IDX_ALIGN:     if (standby) align_reg <= PWDATA[7:0];                    // see R14
        `IDX_RANGE:     if (standby) range_reg <= PWDATA[7:0];                    // see R14
        `IDX_POWER:     power_control_reg <= PWDATA[7:0];
        `IDX_SELF_TEST:
          if (standby)
            self_test_reg <= PWDATA[7:0];
          else
            self_test_reg <= merge(self_test_reg, PWDATA[7:0], `LIVE_MASK_SELF_TEST); // see R14
        `IDX_IRQ_MASK:  irq_mask_reg <= PWDATA[7:0];
        default: ;                                                                // see R18
      endcase
    end
  end

  // Sticky interrupt status: a new event wins over a write-one clear
  always @* begin
    irq_status_next = irq_status_reg;
    if (wr & (index == `IDX_IRQ_STATUS))
      irq_status_next = irq_status_next & ~PWDATA[7:0];
    if (CORE_SAMPLE_VALID)
      irq_status_next[`IRQ_SAMPLE] = 1'b1;
    if (strobe_rise)
      irq_status_next[`IRQ_STROBE] = 1'b1;
    if (refused)
      irq_status_next[`IRQ_REFUSED] = 1'b1;
  end

  always @(posedge CLK) begin
    if (RESET) begin
      irq_status_reg <= `RST_IRQ;
      IRQ            <= 1'b0;
    end else begin
      irq_status_reg <= irq_status_next;
      IRQ            <= |(irq_status_next & irq_mask_reg);
    end
  end

  // Sample capture and the ready level
  always @(posedge CLK) begin
    if (RESET) begin
      x_reg           <= 20'h0_0000;
      y_reg           <= 20'h0_0000;
      z_reg           <= 20'h0_0000;
      temp_reg        <= 12'h000;
      ready_reg       <= 1'b0;
      ready_count_reg <= 16'h0000;
    end else if (CORE_SAMPLE_VALID) begin
      // Core already delays samples by its group delay in aligned modes
      x_reg           <= CORE_X;                                          // see R10
      y_reg           <= CORE_Y;
      z_reg           <= CORE_Z;
      temp_reg        <= CORE_TEMP;
      ready_reg       <= 1'b1;                                            // see R16
      ready_count_reg <= 16'h0000;
    end else if (ready_reg) begin
      // Clears on a data read or part way to the next sample
      if (data_read | (ready_count_reg == READY_HOLD[15:0] - 16'h0001))
        ready_reg <= 1'b0;
      ready_count_reg <= ready_count_reg + 16'h0001;
    end
  end

  // Interrupt-two level: polarity applies here and never to the ready level
  always @(posedge CLK) begin
    if (RESET)
      irq_two_reg <= 1'b0;
    else
      irq_two_reg <= (|(irq_map_reg[`F_MAP_TWO] & CORE_IRQ_EVENTS))
                     ~^ range_reg[`B_IRQ_POLARITY];                       // see R16
  end

  // Strobe handling, interpolation phase and filter control
  always @(posedge CLK) begin
    if (RESET) begin
      strobe_prev_reg <= 1'b0;
      step_count_reg  <= {PERIOD_WIDTH{1'b0}};
      phase_reg       <= 6'h00;
      SYNC_PHASE      <= 6'h00;
      SYNC_STROBE     <= 1'b0;
      FILTER_RESET    <= 1'b0;
      MEASURE_EN      <= 1'b0;
      USE_EXT_CLOCK   <= 1'b0;
      INTERP_EN       <= 1'b0;
      OUTPUT_RATE     <= 4'h0;
      HIGHPASS_CORNER <= 3'h0;
      SELF_TEST       <= 2'h0;
    end else begin
      strobe_prev_reg <= SAMPLE_READY_PIN_IN;
      if (step_count_reg >= step_cycles(filter_reg[`F_OUTPUT_RATE]) - 1'b1) begin
        step_count_reg <= {PERIOD_WIDTH{1'b0}};
        phase_reg      <= phase_reg + 6'h01;                             // see R17
      end else begin
        step_count_reg <= step_count_reg + 1'b1;
      end
      if (strobe_rise)
        SYNC_PHASE <= phase_reg;                                          // see R17
      // Outside samples are paced by the strobe in every aligned mode
      SYNC_STROBE     <= strobe_rise;                                     // see R1
      FILTER_RESET    <= strobe_rise & (align_mode_sel == `ALIGN_PLAIN)
                         & ~clock_source_sel;                             // see R11
      MEASURE_EN      <= ~standby;
      USE_EXT_CLOCK   <= clock_source_sel;                                // see R1
      INTERP_EN       <= (align_mode_sel == `ALIGN_INTERP);               // see R9
      // Rate code reaches the filter unchanged, so the passband is kept
      OUTPUT_RATE     <= filter_reg[`F_OUTPUT_RATE];                      // see R3
      HIGHPASS_CORNER <= filter_reg[`F_HIGHPASS];
      SELF_TEST       <= self_test_reg[`F_SELF_TEST];
    end
  end

  pin_route u_pin_route (
    .clk              (CLK),
    .reset            (RESET),
    .clock_source_sel (clock_source_sel),
    .align_mode_sel   (align_mode_sel),
    .map_two          (irq_map_reg[`F_MAP_TWO]),
    .irq_two_level    (irq_two_reg),
    .ready_level      (sample_ready),
    .irq_two_out      (IRQ_PIN_TWO_OUT),
    .irq_two_oe       (IRQ_PIN_TWO_OE),
    .ready_out        (SAMPLE_READY_PIN_OUT),
    .ready_oe         (SAMPLE_READY_PIN_OE)
  );

endmodule // accel_sync_pinmux_regmap

`default_nettype wire

// ===== verification/accel_sync_monitor.sv
// Concurrent checks on the ports of the register bank
`timescale 1ns/1ns
`default_nettype none
module accel_sync_monitor (
  // Clock, reset and bus
  input wire        CLK,
  input wire        RESET,
  input wire        PSEL,
  input wire        PENABLE,
  input wire        PWRITE,
  input wire [7:0]  PADDR,
  input wire [31:0] PWDATA,
  input wire        PREADY,
  input wire        PSLVERR,
  // Pins and core control
  input wire        IRQ_PIN_TWO_OE,
  input wire        SAMPLE_READY_PIN_IN,
  input wire        SAMPLE_READY_PIN_OE,
  input wire        MEASURE_EN,
  input wire        USE_EXT_CLOCK,
  input wire        INTERP_EN,
  input wire [3:0]  OUTPUT_RATE,
  input wire [2:0]  HIGHPASS_CORNER,
  input wire        SYNC_STROBE,
  input wire        FILTER_RESET
);
  wire wr_done = PSEL && PENABLE && PREADY && PWRITE && !PSLVERR;
  reg [2:0] hp_reg, align_reg;
  // Write data kept for the delayed checks
  always @(posedge CLK) begin
    if (wr_done && PADDR == 8'hA0) hp_reg <= PWDATA[6:4];
    if (wr_done && PADDR == 8'hAC) align_reg <= PWDATA[2:0];
  end
  default clocking mon_cb @(posedge CLK);
  endclocking
  default disable iff (RESET);
  ext_pin_off_a: assert property (
    USE_EXT_CLOCK && $past(USE_EXT_CLOCK) |-> !IRQ_PIN_TWO_OE)
    else $error("pin two driven with outside clock selected");
  strobe_pin_in_a: assert property (
    INTERP_EN && $past(INTERP_EN) |-> !SAMPLE_READY_PIN_OE)
    else $error("ready pin driven while interpolating");
  strobe_taken_a: assert property (
    SAMPLE_READY_PIN_IN && !$past(SAMPLE_READY_PIN_IN) && !SAMPLE_READY_PIN_OE
    && !$past(SAMPLE_READY_PIN_OE) |=> SYNC_STROBE)
    else $error("strobe edge not taken");
  strobe_cause_a: assert property (
    SYNC_STROBE |-> $past(SAMPLE_READY_PIN_IN) && !$past(SAMPLE_READY_PIN_IN, 2))
    else $error("strobe pulse without a fresh rising edge");
  filter_reset_a: assert property (
    FILTER_RESET |-> SYNC_STROBE && !USE_EXT_CLOCK && !INTERP_EN)
    else $error("filter reset outside internal plain alignment");
  align_set_a: assert property (
    wr_done && PADDR == 8'hAC && !MEASURE_EN |-> ##2
    INTERP_EN == (align_reg[1:0] == 2'b10) && USE_EXT_CLOCK == align_reg[2])
    else $error("alignment write not applied in standby");
  align_hold_a: assert property (
    wr_done && PADDR == 8'hAC && MEASURE_EN |=>
    ($stable(INTERP_EN) && $stable(USE_EXT_CLOCK)) [*2])
    else $error("alignment changed while measuring");
  rate_hold_a: assert property (
    wr_done && PADDR == 8'hA0 && MEASURE_EN |=> $stable(OUTPUT_RATE) [*2])
    else $error("output rate changed while measuring");
  corner_live_a: assert property (
    wr_done && PADDR == 8'hA0 |-> ##2 HIGHPASS_CORNER == hp_reg)
    else $error("highpass corner not updated");
endmodule // accel_sync_monitor
bind accel_sync_pinmux_regmap accel_sync_monitor i_mon (.CLK, .RESET, .PSEL, .PENABLE,
  .PWRITE, .PADDR, .PWDATA, .PREADY, .PSLVERR, .IRQ_PIN_TWO_OE, .SAMPLE_READY_PIN_IN,
  .SAMPLE_READY_PIN_OE, .MEASURE_EN, .USE_EXT_CLOCK, .INTERP_EN, .OUTPUT_RATE,
  .HIGHPASS_CORNER, .SYNC_STROBE, .FILTER_RESET);
`default_nettype wire

// ===== verification/host_sync_model.sv
// Host-side model: outside sample clock and sync strobes
`timescale 1ns/1ns
`default_nettype none
module host_sync_model (
  // Clock and reset
  input  wire  clk,
  input  wire  reset,
  // Request from the test sequence
  input  wire  strobe_req,
  // Lines toward the device, and the busy flag back to the test sequence
  output logic ext_clock,
  output logic sync_line,
  output logic busy
);
  localparam int HIGH_CYCLES = 40;   // 4.0 us, over four outside clock cycles
  localparam int GAP_CYCLES  = 2500; // 250 us apart, under 4000 per second
  int cnt, k;
  // Half periods of 488 or 489 ns average out to exactly 1.024 MHz
  initial begin
    ext_clock = 1'b0;
    k = 0;
    forever begin
      #((((k + 1) * 15625) / 32) - ((k * 15625) / 32));
      ext_clock = ~ext_clock;
      k = (k + 1) % 32;
    end
  end
  always @(posedge clk) begin
    if (reset) begin
      cnt <= 0;
      sync_line <= 1'b0;
      busy <= 1'b0;
    end else if (busy) begin
      cnt <= cnt + 1;
      sync_line <= (cnt < HIGH_CYCLES - 1);
      if (cnt == GAP_CYCLES - 1) busy <= 1'b0;
    end else if (strobe_req) begin
      busy <= 1'b1;
      cnt <= 0;
      sync_line <= 1'b1;
    end
  end
endmodule // host_sync_model
`default_nettype wire

// ===== verification/tb.sv
// Register, pin routing and strobe tests of the register bank
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic clk, reset, psel, penable, pwrite, sample_valid, strobe_req, er;
  logic [7:0] paddr, rd;
  logic [31:0] pwdata;
  logic [19:0] core_x;
  logic [11:0] core_temp;
  logic [6:0] queue_fill;
  logic [3:0] flags, events;
  wire [31:0] prdata;
  wire [3:0] out_rate;
  wire pready, pslverr, irq, two_out, two_oe, rdy_out, rdy_oe, measure_en;
  wire use_ext, interp_en, sync_strobe, filter_reset, ext_clock, sync_line, busy;
  wire         pin_two = two_oe ? two_out : ext_clock;
  wire         ready_pin = rdy_oe ? rdy_out : sync_line;
  int errors = 0, total_checks = 0, n_sync = 0, n_fres = 0;
  int i, ms, mf;
  logic [7:0]  modes [4] = '{8'h01, 8'h05, 8'h06, 8'h00};

  accel_sync_pinmux_regmap i_dut (.CLK(clk), .RESET(reset), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .IRQ(irq), .IRQ_PIN_TWO_IN(pin_two), .IRQ_PIN_TWO_OUT(two_out),
    .IRQ_PIN_TWO_OE(two_oe), .SAMPLE_READY_PIN_IN(ready_pin),
    .SAMPLE_READY_PIN_OUT(rdy_out), .SAMPLE_READY_PIN_OE(rdy_oe),
    .CORE_SAMPLE_VALID(sample_valid), .CORE_X(core_x), .CORE_Y(~core_x),
    .CORE_Z(core_x ^ 20'h0F0F0), .CORE_TEMP(core_temp), .CORE_QUEUE_FILL(queue_fill),
    .CORE_STORE_BUSY(flags[3]), .CORE_ACTIVITY(flags[2]), .CORE_OVERRUN(flags[1]),
    .CORE_WATERMARK(flags[0]), .CORE_IRQ_EVENTS(events), .MEASURE_EN(measure_en),
    .USE_EXT_CLOCK(use_ext), .INTERP_EN(interp_en), .OUTPUT_RATE(out_rate),
    .HIGHPASS_CORNER(), .SELF_TEST(), .SYNC_STROBE(sync_strobe), .SYNC_PHASE(),
    .FILTER_RESET(filter_reset));
  host_sync_model i_host (.clk(clk), .reset(reset), .strobe_req(strobe_req),
    .ext_clock(ext_clock), .sync_line(sync_line), .busy(busy));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    if (sync_strobe === 1'b1) n_sync <= n_sync + 1;
    if (filter_reset === 1'b1) n_fres <= n_fres + 1;
  end

  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx[5:0], 2'b00};
    pwdata <= {24'h000000, wd};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) errors++;
    rd = prdata[7:0];
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Error flag sits above the data byte
  task automatic rchk(input logic [7:0] idx, input logic [8:0] exp);
    apb(1'b0, idx, 8'h00);
    chk({er, rd}, exp);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic sample;
    @(posedge clk) sample_valid <= 1'b1;
    @(posedge clk) sample_valid <= 1'b0;
  endtask
  task automatic strobe;
    int n;
    @(posedge clk) strobe_req <= 1'b1;
    @(posedge clk) strobe_req <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (busy === 1'b1 && n < 3000);
  endtask

  initial begin
    reset = 1'b1;
    {psel, penable, pwrite, sample_valid, strobe_req, paddr, pwdata} = '0;
    {core_x, core_temp, flags, events} = '0;
    queue_fill = 7'h7F;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    rchk(8'h00, 9'h05A);
    rchk(8'h01, 9'h03C);
    rchk(8'h03, 9'h002);
    apb(1'b1, 8'h02, 8'hFF);
    rchk(8'h02, 9'h077);
    rchk(8'h10, 9'h100);
    rchk(8'h2C, 9'h081);
    rchk(8'h2D, 9'h001);
    chk({two_oe, two_out, rdy_oe}, 3'b101);
    $display("test reset values done");
    for (i = 0; i < 4; i++) begin
      @(posedge clk) flags <= 4'h1 << i;
      rchk(8'h04, 9'h002 << i);
    end
    flags <= 4'h0;
    rchk(8'h05, 9'h07F);
    $display("test event flags done");
    core_x <= 20'hABCDE;
    core_temp <= 12'hABC;
    for (i = 0; i < 2; i++) begin
      apb(1'b1, 8'h2C, i ? 8'h41 : 8'h01);
      sample;
      settle(2);
      chk(rdy_out, 1'b1);
      rchk(8'h08, 9'h0AB);
      settle(2);
      chk(rdy_out, 1'b0);
    end
    rchk(8'h0A, 9'h0E0);
    rchk(8'h0B, 9'h054);
    rchk(8'h06, 9'h00A);
    rchk(8'h07, 9'h0BC);
    $display("test sample ready done");
    apb(1'b1, 8'h2A, 8'h10);
    settle(4);
    chk({two_oe, two_out}, 2'b10);
    @(posedge clk) events <= 4'h1;
    settle(4);
    chk({two_oe, two_out}, 2'b11);
    apb(1'b1, 8'h2C, 8'h01);
    settle(4);
    chk({two_oe, two_out}, 2'b10);
    @(posedge clk) events <= 4'h0;
    apb(1'b1, 8'h2A, 8'h00);
    apb(1'b1, 8'h2B, 8'h01);
    settle(2);
    chk({two_oe, two_out, rdy_oe}, 3'b100);
    sample;
    settle(2);
    chk({two_oe, two_out, rdy_oe}, 3'b110);
    rchk(8'h08, 9'h0AB);
    apb(1'b1, 8'h2A, 8'h10);
    apb(1'b1, 8'h2B, 8'h06);
    settle(2);
    chk({two_oe, interp_en, use_ext}, 3'b011);
    $display("test pin routing done");
    apb(1'b1, 8'h31, 8'h02);
    for (i = 0; i < 4; i++) begin
      apb(1'b1, 8'h2B, modes[i]);
      settle(2);
      ms = n_sync;
      mf = n_fres;
      strobe;
      chk(n_sync - ms, i < 3);
      chk(n_fres - mf, i == 0);
      if (i == 2) chk(irq, 1'b1);
    end
    apb(1'b1, 8'h30, 8'h07);
    settle(1);
    chk(irq, 1'b0);
    rchk(8'h30, 9'h000);
    $display("test strobes done");
    apb(1'b1, 8'h2B, 8'h05);
    apb(1'b1, 8'h28, 8'h03);
    apb(1'b1, 8'h2D, 8'h00);
    settle(2);
    chk(measure_en, 1'b1);
    apb(1'b1, 8'h2B, 8'h02);
    rchk(8'h2B, 9'h005);
    apb(1'b1, 8'h28, 8'h35);
    rchk(8'h28, 9'h033);
    chk(out_rate, 4'h3);
    apb(1'b1, 8'h2E, 8'hFF);
    rchk(8'h2E, 9'h003);
    apb(1'b1, 8'h2A, 8'h20);
    rchk(8'h2A, 9'h020);
    rchk(8'h30, 9'h004);
    apb(1'b1, 8'h2F, 8'h5A);
    rchk(8'h2B, 9'h000);
    rchk(8'h2D, 9'h001);
    $display("test measurement lock done");
    report_and_stop;
  end
  // Tests take about 10300 cycles
  initial begin
    #3000000;
    errors++;
    report_and_stop;
  end
endmodule // tb
`default_nettype wire
